//--- gpio_port_pkg.sv
/*
  Constants for the eight-pin general-purpose port: register offsets,
  reset values, widths and bus answers.
  Assumes a 32-bit Avalon-MM slave with word addresses given as byte offsets.
*/
`default_nettype none
package gpio_port_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned SEL_WIDTH = 4;
  localparam logic [ADDR_WIDTH-1:0] OUTPUT_DATA_OFFSET = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] DIRECTION_OFFSET = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] PIN_LEVEL_OFFSET = 4'h8;
  localparam logic [PORT_WIDTH-1:0] OUTPUT_DATA_RESET = 8'h00;
  localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 8'h00;
  localparam logic [PORT_WIDTH-1:0] DIRECTION_READ_VALUE = 8'hff;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODEERROR = 2'h3;
  localparam logic [SEL_WIDTH-1:0] GPIO_SELECT_RESET = 4'h0;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_type;
endpackage
`default_nettype wire

//--- pin_select.sv
/*
  Per-pin ownership decode: which pins the LCD segment-select field hands
  to general-purpose use.
  Assumes the select field is stable and synchronous to the clock.
*/
`default_nettype none
module pin_select
  import gpio_port_pkg::*;
(
  input wire logic [SEL_WIDTH-1:0] segment_select_in,
  input wire logic [PORT_WIDTH-1:0] gpio_select_mask_in,
  output logic [PORT_WIDTH-1:0] gpio_owned_out
);
  // The field's encoding is open, so the grant mask carries ownership; the reset code grants every pin
  function automatic logic owned(input logic [SEL_WIDTH-1:0] sel, input logic mask_bit);
    owned = mask_bit | (sel == GPIO_SELECT_RESET);
  endfunction

  genvar i;
  generate
    for (i = 0; i < PORT_WIDTH; i++) begin : g_own
      assign gpio_owned_out[i] = owned(segment_select_in, gpio_select_mask_in[i]);
    end
  endgenerate
endmodule // pin_select

//--- pin_driver.sv
/*
  Per-pin output driver stage, registered so pads change one edge after
  the register update.
  Assumes an external pad ring that resolves level from enable.
*/
`default_nettype none
module pin_driver
  import gpio_port_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [PORT_WIDTH-1:0] data_in,
  input wire logic [PORT_WIDTH-1:0] drive_in,
  output logic [PORT_WIDTH-1:0] pin_out,
  output logic [PORT_WIDTH-1:0] pin_oe_n_out
);
  logic [PORT_WIDTH-1:0] pin_q, pin_d, oe_n_q, oe_n_d;

  always_comb begin
    pin_d = data_in & drive_in;
    oe_n_d = ~drive_in;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_q <= OUTPUT_DATA_RESET;
      oe_n_q <= ~DIRECTION_RESET;
    end else begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_n_out = oe_n_q;
endmodule // pin_driver

//--- eight_bit_io_port.sv
/*
  Eight-pin general-purpose input/output port with an Avalon-MM register
  slave, a write-only direction register and an output data register.
  Assumes pin inputs and the LCD segment-select field are synchronous to
  clock_in, and that the pad ring resolves pins from the enables.
*/
// The Avalon-MM slave port and the register offsets were left to the implementer.
//
// Summary of operation
// - Eight-bit output data register holds the level each output pin drives.
// - Port read returns stored output data for bits whose direction is one.
// - Port read returns live pin level for bits whose direction is zero.
// - Reset clears the output data register to zero.
// - Each direction bit independently selects output (one) or input (zero).
// - Settings govern a pin only when segment select gives it to general use.
// - Reset clears all direction bits, so every pin starts as input.
// - Direction register is write-only and always reads as all ones.
`default_nettype none
module eight_bit_io_port
  import gpio_port_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [ADDR_WIDTH-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  input wire logic [SEL_WIDTH-1:0] segment_select_in,
  input wire logic [PORT_WIDTH-1:0] gpio_select_mask_in,
  input wire logic [PORT_WIDTH-1:0] port_pin_in,
  output logic [PORT_WIDTH-1:0] port_pin_out,
  output logic [PORT_WIDTH-1:0] port_pin_oe_n_out
);
  bus_state_type state_q, state_d;
  logic [PORT_WIDTH-1:0] port_output_data_q, port_output_data_d;
  logic [PORT_WIDTH-1:0] port_direction_q, port_direction_d;
  logic [31:0] readdata_q, readdata_d;
  logic [1:0] resp_q, resp_d;
  logic wait_q, wait_d;
  logic [PORT_WIDTH-1:0] gpio_owned;
  logic [PORT_WIDTH-1:0] drive_en;
  logic [PORT_WIDTH-1:0] port_read_value;

  pin_select u_pin_select (
    .segment_select_in(segment_select_in),
    .gpio_select_mask_in(gpio_select_mask_in),
    .gpio_owned_out(gpio_owned)
  );

  // A pin drives only if it is general purpose and set as output
  assign drive_en = port_direction_q & gpio_owned;

  pin_driver u_pin_driver (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .data_in(port_output_data_q),
    .drive_in(drive_en),
    .pin_out(port_pin_out),
    .pin_oe_n_out(port_pin_oe_n_out)
  );

  // Mix stored data and live levels bit by bit
  assign port_read_value = (port_direction_q & port_output_data_q)
                         | (~port_direction_q & port_pin_in);

  // Every access takes one wait cycle: waitrequest is registered, so the
  // answer costs a cycle but keeps all bus outputs straight from flops.
  always_comb begin
    state_d = state_q;
    port_output_data_d = port_output_data_q;
    port_direction_d = port_direction_q;
    readdata_d = readdata_q;
    resp_d = resp_q;
    wait_d = 1'b1;
    case (state_q)
      BUS_IDLE: begin
        if (avs_write_in) begin
          state_d = BUS_ANSWER;
          wait_d = 1'b0;
          resp_d = RESP_OKAY;
          if (avs_address_in == OUTPUT_DATA_OFFSET) begin
            if (avs_byteenable_in[0]) begin
              port_output_data_d = avs_writedata_in[PORT_WIDTH-1:0];
            end
          end else if (avs_address_in == DIRECTION_OFFSET) begin
            if (avs_byteenable_in[0]) begin
              port_direction_d = avs_writedata_in[PORT_WIDTH-1:0];
            end
          end else if (avs_address_in == PIN_LEVEL_OFFSET) begin
            resp_d = RESP_OKAY;
          end else begin
            resp_d = RESP_DECODEERROR;
          end
        end else if (avs_read_in) begin
          state_d = BUS_ANSWER;
          wait_d = 1'b0;
          resp_d = RESP_OKAY;
          if (avs_address_in == OUTPUT_DATA_OFFSET) begin
            readdata_d = {{(32-PORT_WIDTH){1'b0}}, port_read_value};
          end else if (avs_address_in == DIRECTION_OFFSET) begin
            readdata_d = {{(32-PORT_WIDTH){1'b0}}, DIRECTION_READ_VALUE};
          end else if (avs_address_in == PIN_LEVEL_OFFSET) begin
            readdata_d = {{(32-PORT_WIDTH){1'b0}}, port_pin_in};
          end else begin
            readdata_d = UNMAPPED_READ_VALUE;
            resp_d = RESP_DECODEERROR;
          end
        end
      end
      BUS_ANSWER: begin
        state_d = BUS_IDLE;
        wait_d = 1'b1;
      end
      default: begin
        state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= BUS_IDLE;
      port_output_data_q <= OUTPUT_DATA_RESET;
      port_direction_q <= DIRECTION_RESET;
      readdata_q <= UNMAPPED_READ_VALUE;
      resp_q <= RESP_OKAY;
      wait_q <= 1'b1;
    end else begin
      state_q <= state_d;
      port_output_data_q <= port_output_data_d;
      port_direction_q <= port_direction_d;
      readdata_q <= readdata_d;
      resp_q <= resp_d;
      wait_q <= wait_d;
    end
  end

  assign avs_readdata_out = readdata_q;
  assign avs_waitrequest_out = wait_q;
  assign avs_response_out = resp_q;

  // Pads follow data one edge after the register update, which is the edge before a write is accepted, so pads change on the accepting edge
  sequence write_data_s;
    avs_write_in && !avs_waitrequest_out && avs_address_in == OUTPUT_DATA_OFFSET && avs_byteenable_in[0];
  endsequence

  drive_follows_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (drive_en == $past(drive_en)) ##1 (drive_en == $past(drive_en)) |->
      (port_pin_out == (port_output_data_q & drive_en)) or $changed(port_output_data_q))
    else $error("Output pin does not follow data");

  output_reg_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    write_data_s |=> port_output_data_q == $past(avs_writedata_in[PORT_WIDTH-1:0]))
    else $error("Output data write lost");

  readback_mix_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_q == BUS_IDLE && avs_read_in && avs_address_in == OUTPUT_DATA_OFFSET) |=>
      ((avs_readdata_out[PORT_WIDTH-1:0] & $past(port_direction_q)) == ($past(port_output_data_q) & $past(port_direction_q))))
    else $error("Output bit read wrong");

  readback_pin_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_q == BUS_IDLE && avs_read_in && avs_address_in == OUTPUT_DATA_OFFSET) |=>
      ((avs_readdata_out[PORT_WIDTH-1:0] & ~$past(port_direction_q)) == ($past(port_pin_in) & ~$past(port_direction_q))))
    else $error("Input bit read wrong");

  reset_data_a: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> port_output_data_q == OUTPUT_DATA_RESET)
    else $error("Output data not cleared by reset");

  input_float_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ##1 (~$past(drive_en) == port_pin_oe_n_out))
    else $error("Pin enable disagrees with direction");

  owned_only_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(~gpio_owned) != 8'h00 |-> ((port_pin_oe_n_out | $past(gpio_owned)) == 8'hff))
    else $error("Unowned pin driven");

  reset_dir_a: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> port_direction_q == DIRECTION_RESET && port_pin_oe_n_out == 8'hff)
    else $error("Direction not cleared by reset");

  dir_read_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_q == BUS_IDLE && avs_read_in && !avs_write_in && avs_address_in == DIRECTION_OFFSET) |=>
      !avs_waitrequest_out ##0 avs_readdata_out[PORT_WIDTH-1:0] == 8'hff)
    else $error("Direction read not all ones");

  // Address classes, shared by the bus checks below
  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] addr);
    is_mapped = (addr == OUTPUT_DATA_OFFSET) || (addr == DIRECTION_OFFSET) || (addr == PIN_LEVEL_OFFSET);
  endfunction

  // A request is taken only while idle; its answer follows one edge later
  sequence take_s;
    state_q == BUS_IDLE && (avs_read_in || avs_write_in);
  endsequence

  sequence answer_s;
    !avs_waitrequest_out && state_q == BUS_ANSWER;
  endsequence

  sequence read_take_s;
    state_q == BUS_IDLE && avs_read_in && !avs_write_in;
  endsequence

  sequence write_take_s;
    state_q == BUS_IDLE && avs_write_in;
  endsequence

  answer_next_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    take_s |=> answer_s)
    else $error("Request not answered after one cycle");

  wait_single_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("Waitrequest low for more than one cycle");

  idle_wait_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state_q == BUS_IDLE |-> avs_waitrequest_out)
    else $error("Waitrequest low while idle");

  no_request_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_q == BUS_IDLE && !avs_read_in && !avs_write_in) |=> avs_waitrequest_out)
    else $error("Answer without a request");

  answer_end_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    state_q == BUS_ANSWER |=> state_q == BUS_IDLE)
    else $error("Answer state not left");

  unmapped_read_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (read_take_s and !is_mapped(avs_address_in)) |=>
      answer_s ##0 (avs_response_out == RESP_DECODEERROR && avs_readdata_out == UNMAPPED_READ_VALUE))
    else $error("Unmapped read not refused");

  unmapped_write_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (write_take_s and !is_mapped(avs_address_in)) |=>
      (avs_response_out == RESP_DECODEERROR && $stable(port_output_data_q) && $stable(port_direction_q)))
    else $error("Unmapped write not refused");

  mapped_okay_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (take_s and is_mapped(avs_address_in)) |=> avs_response_out == RESP_OKAY)
    else $error("Mapped access not answered okay");

  upper_zero_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !avs_waitrequest_out |-> avs_readdata_out[31:PORT_WIDTH] == '0)
    else $error("Upper read data not zero");

  dir_write_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (write_take_s and (avs_address_in == DIRECTION_OFFSET && avs_byteenable_in[0])) |=>
      port_direction_q == $past(avs_writedata_in[PORT_WIDTH-1:0]))
    else $error("Direction write lost");

  level_write_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (write_take_s and avs_address_in == PIN_LEVEL_OFFSET) |=>
      ($stable(port_output_data_q) && $stable(port_direction_q)))
    else $error("Raw level write changed a register");

  raw_level_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (read_take_s and avs_address_in == PIN_LEVEL_OFFSET) |=>
      avs_readdata_out[PORT_WIDTH-1:0] == $past(port_pin_in))
    else $error("Raw level read wrong");

  regs_hold_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (state_q != BUS_IDLE || !avs_write_in) |=> ($stable(port_output_data_q) && $stable(port_direction_q)))
    else $error("Register changed without a write");

  // Read data must stand until the next read answer, so writes leave it alone
  readdata_hold_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !(state_q == BUS_IDLE && avs_read_in) |=> $stable(avs_readdata_out))
    else $error("Read data changed without a read");

  dir_read_keep_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (read_take_s and avs_address_in == DIRECTION_OFFSET) |=> $stable(port_direction_q))
    else $error("Direction read disturbed the register");

  undriven_low_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (port_pin_out & port_pin_oe_n_out) == OUTPUT_DATA_RESET)
    else $error("Undriven pin shows data");

  pin_data_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ##1 (port_pin_out == ($past(port_output_data_q) & $past(drive_en))))
    else $error("Pin data lags more than one edge");

  reset_wait_a: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> (avs_waitrequest_out && state_q == BUS_IDLE))
    else $error("Bus not idle after reset");

  reset_pin_a: assert property (@(posedge clock_in)
    $rose(nrst_in) |-> port_pin_out == OUTPUT_DATA_RESET)
    else $error("Pin data not cleared by reset");
endmodule // eight_bit_io_port
`default_nettype wire

//--- board_pins.sv
/*
  Board-side model of the eight port pins: each pad level is resolved from
  the port's output enable, its driven data and the board circuitry.
  Assumes the board always drives a defined level on undriven pads.
*/
`default_nettype none
module board_pins
  import gpio_port_pkg::*;
(
  input wire logic [PORT_WIDTH-1:0] pin_out_in,
  input wire logic [PORT_WIDTH-1:0] oe_n_in,
  input wire logic [PORT_WIDTH-1:0] board_level_in,
  output logic [PORT_WIDTH-1:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pad follows the port, so raw level reads of driven pins see the driven level too
  assign pin_level_out = (~oe_n_in & pin_out_in) | (oe_n_in & board_level_in);
endmodule // board_pins
`default_nettype wire

//--- test_eight_bit_io_port.sv
/*
  Self-checking bench for the eight-pin port: Avalon-MM register traffic,
  pin resolution through the board model, reset and ownership checks.
  Assumes the one-cycle answer of the slave and registered pin outputs.
*/
`default_nettype none
module test_eight_bit_io_port
  import gpio_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [ADDR_WIDTH-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  logic [1:0] avs_response_out;
  logic [SEL_WIDTH-1:0] segment_select_in;
  logic [PORT_WIDTH-1:0] gpio_select_mask_in, board_q, port_pin_in, port_pin_out, port_pin_oe_n_out;
  logic [PORT_WIDTH-1:0] dir_v, dat_v, brd_v, msk_v;
  logic [15:0] lfsr_q;
  logic [33:0] exp_q[$];
  int error_cnt, checks;
  eight_bit_io_port u_eight_bit_io_port (.clock_in(clock_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .avs_response_out(avs_response_out),
    .segment_select_in(segment_select_in), .gpio_select_mask_in(gpio_select_mask_in),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe_n_out(port_pin_oe_n_out));
  board_pins u_board_pins (.pin_out_in(port_pin_out), .oe_n_in(port_pin_oe_n_out), .board_level_in(board_q),
    .pin_level_out(port_pin_in));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] expd);
    checks++;
    if (seen !== expd) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One request, held until waitrequest is sampled low; a read queues its expected answer
  task automatic bus(input logic wr, input logic [ADDR_WIDTH-1:0] a, input logic [7:0] d, input logic [33:0] expd);
    int n;
    n = 0;
    if (!wr) exp_q.push_back(expd);
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      error_cnt++;
      complete_run();
    end
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clock_in);
  endtask
  always @(posedge clock_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
      check({avs_response_out, avs_readdata_out}, exp_q.size() > 0 ? exp_q.pop_front() : 34'h0);
    end
  end
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    complete_run();
  end
  initial begin
    {nrst_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
    avs_byteenable_in = 4'hf;
    segment_select_in = 4'h3;
    gpio_select_mask_in = 8'hff;
    board_q = 8'h5a;
    lfsr_q = 16'hc3c6;
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    check({26'h0, port_pin_oe_n_out}, {26'h0, 8'hff});
    bus(1'b0, OUTPUT_DATA_OFFSET, 8'h00, {RESP_OKAY, 24'h0, 8'h5a});
    bus(1'b0, PIN_LEVEL_OFFSET, 8'h00, {RESP_OKAY, 24'h0, 8'h5a});
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      {dir_v, dat_v} = lfsr_q;
      brd_v = lfsr_q[11:4];
      msk_v = lfsr_q[13:6];
      board_q <= brd_v;
      gpio_select_mask_in <= msk_v;
      bus(1'b1, DIRECTION_OFFSET, dir_v, '0);
      bus(1'b1, OUTPUT_DATA_OFFSET, dat_v, '0);
      bus(1'b0, OUTPUT_DATA_OFFSET, 8'h00, {RESP_OKAY, 24'h0, (dat_v & dir_v) | (brd_v & ~dir_v)});
      bus(1'b0, DIRECTION_OFFSET, 8'h00, {RESP_OKAY, 24'h0, DIRECTION_READ_VALUE});
      check({18'h0, port_pin_oe_n_out, port_pin_out}, {18'h0, ~(dir_v & msk_v), dat_v & dir_v & msk_v});
    end
    $display("port traffic test done");
    gpio_select_mask_in <= 8'h00;
    segment_select_in <= 4'h0;
    repeat (3) @(posedge clock_in);
    check({26'h0, port_pin_oe_n_out}, {26'h0, ~dir_v});
    segment_select_in <= 4'h5;
    repeat (3) @(posedge clock_in);
    check({18'h0, port_pin_oe_n_out, port_pin_out}, {18'h0, 8'hff, 8'h00});
    $display("ownership test done");
    bus(1'b1, 4'hc, 8'hff, '0);
    bus(1'b0, 4'hc, 8'h00, {RESP_DECODEERROR, UNMAPPED_READ_VALUE});
    bus(1'b1, DIRECTION_OFFSET, 8'hff, '0);
    bus(1'b0, OUTPUT_DATA_OFFSET, 8'h00, {RESP_OKAY, 24'h0, dat_v});
    $display("unmapped test done");
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    check({26'h0, port_pin_oe_n_out}, {26'h0, 8'hff});
    bus(1'b1, DIRECTION_OFFSET, 8'hff, '0);
    bus(1'b0, OUTPUT_DATA_OFFSET, 8'h00, {RESP_OKAY, 24'h0, OUTPUT_DATA_RESET});
    $display("second reset test done");
    repeat (3) @(posedge clock_in);
    complete_run();
  end
endmodule // test_eight_bit_io_port
`default_nettype wire
